/* File: inc/rtf_trim_map.svh */
/*
   Constants of the trim and fault-flag block: field widths, trim codes,
   reset values and timing counts.
   Assumes inclusion by its bare name from the package; the design uses its macros without including it.
*/
`ifndef RTF_TRIM_MAP_SVH
`define RTF_TRIM_MAP_SVH

`define RTF_TRIM_W 7
`define RTF_CTRL_W 11
`define RTF_IRQ_W 3

`define RTF_TRIM_OFF_ZERO 7'h00
`define RTF_TRIM_OFF_PLUS1 7'h01
`define RTF_TRIM_OFF_M64 7'h40
`define RTF_TRIM_OFF_M63 7'h41
`define RTF_TRIM_GAIN_BASE 8'h01
`define RTF_TRIM_LOSS_BASE 8'h80
`define RTF_TRIM_SIGN_BIT 6
`define RTF_TRIM_STEP 16'h0002
`define RTF_TRIM_PERIOD_S 20
`define RTF_TRIM_LAST_SEC 5'h13

`define RTF_OSC_HZ 32768
`define RTF_SYS_HZ 10000000
`define RTF_SEC_LAST 16'h7FFF

`define RTF_WIN_US 7800
`define RTF_WIN_CYC ((`RTF_WIN_US * `RTF_OSC_HZ) / 1000000)

`define RTF_HALT_US 1000
`define RTF_HALT_CYC ((`RTF_HALT_US * (`RTF_SYS_HZ / 1000000)))

`define RTF_HALT_RST 1'b1
`define RTF_LOW_RST 1'b0
`define RTF_CTRL_RST 11'h000
`define RTF_TRIM_RST 7'h00
`define RTF_IRQ_RST 3'h0

`define RTF_CTRL_WEEKLY_ALARM_ENABLE 0
`define RTF_CTRL_DAILY_ALARM_ENABLE 1
`define RTF_CTRL_H24 2
`define RTF_CTRL_CLKA 3
`define RTF_CTRL_CLKB 4
`define RTF_CTRL_TEST 5
`define RTF_CTRL_PSEL 6
`define RTF_CTRL_VSEL 9
`define RTF_CTRL_SCR 10

`endif

/* File: inc/rtf_pkg.sv */
/*
   Types shared by the trim and fault-flag block.
   Assumes the constant header is on the include path.
*/
`include "rtf_trim_map.svh"

package rtf_pkg;

   typedef logic [`RTF_TRIM_W-1:0] rtf_code_type;

   typedef enum logic [1:0] {
      RTF_TRIM_NONE,
      RTF_TRIM_SLOW,
      RTF_TRIM_FAST
   } rtf_mode_type;

endpackage : rtf_pkg

/* File: verilog/rtf_sync.sv */
/*
   Two-flop synchroniser for a vector of independent levels.
   Assumes each bit changes at most once per few destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module rtf_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Only the second stage looks at the first.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule : rtf_sync

`default_nettype wire

/* File: verilog/rtf_trim_and_fault_flags.sv */
/*
   Timekeeping trim and fault flags of a serial real-time clock: the trimmed
   one-second timebase on the oscillator clock, the oscillator-halt and
   low-supply sticky flags, and the control bits that a halt clears.
   Assumes the serial port decodes host writes into the strobes below on
   sys_clk, analog comparators drive the supply inputs, and rst_n stands
   for power-up from zero volts.
*/
// Notes on behaviour
// - When trim is on, every twentieth second is lengthened or shortened by the code.
// - Codes 0, +1, -64 and -63 turn trimming off.
// - Seven-bit code: gain counted from 01h, loss of n coded as 80h minus n.
// - Codes 02h to 3Fh slow the count in steps of about 3.05 ppm.
// - Codes 7Fh down to 42h speed the count in steps of about 3.05 ppm.
// - Trim changes only the internal second count, never the raw clock output.
// - Halt flag stays one until the host writes zero; low-supply flag until a zero write or a rising halt flag.
// - Low supply is below 2.1 V when select is 0, 1.6 V when 1.
// - A rising halt flag forces the low-supply flag to zero.
// - Halt detection runs only with chip enable low; result is kept after.
// - A rising halt flag clears trim code, control bits and interrupt flags.
// - Power-up from zero volts sets the halt flag.
// - Supply is sampled only in a 7.8 ms window once per second.
// - Sampling stops while the low-supply flag is one.
`timescale 1ns/1ps
`default_nettype none

module rtf_trim_and_fault_flags
   import rtf_pkg::*;
#(
   parameter int unsigned HALT_CYCLES = `RTF_HALT_CYC,
   parameter int unsigned WIN_CYCLES = `RTF_WIN_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic osc_clk,
   input wire logic chip_enable,
   input wire logic supply_below_2v1,
   input wire logic supply_below_1v6,
   input wire logic trim_wr,
   input wire logic [6:0] trim_wdata,
   input wire logic ctrl_wr,
   input wire logic wr_weekly_alarm_enable,
   input wire logic wr_daily_alarm_enable,
   input wire logic wr_hour24_select,
   input wire logic wr_clkout_enable_a,
   input wire logic wr_clkout_enable_b,
   input wire logic wr_test_mode,
   input wire logic [2:0] wr_periodic_select,
   input wire logic wr_supply_threshold_select,
   input wire logic wr_scratch,
   input wire logic flag_wr,
   input wire logic wr_osc_halt_flag,
   input wire logic wr_low_supply_flag,
   input wire logic [2:0] wr_irq_flag,
   input wire logic [2:0] irq_event,
   output logic osc_halt_flag,
   output logic low_supply_flag,
   output logic [6:0] trim_code,
   output logic trim_active,
   output logic weekly_alarm_enable,
   output logic daily_alarm_enable,
   output logic hour24_select,
   output logic clkout_enable_a,
   output logic clkout_enable_b,
   output logic test_mode,
   output logic [2:0] periodic_select,
   output logic supply_threshold_select,
   output logic scratch,
   output logic [2:0] irq_flag,
   output logic monitor_active,
   output logic sec_tick
);

   // Decodes a trim code into off, slow or fast.
   function automatic rtf_mode_type trim_mode(input rtf_code_type code);
      rtf_mode_type mode;
      mode = RTF_TRIM_NONE;
      if (code == `RTF_TRIM_OFF_ZERO || code == `RTF_TRIM_OFF_PLUS1 ||
          code == `RTF_TRIM_OFF_M64 || code == `RTF_TRIM_OFF_M63) begin
         mode = RTF_TRIM_NONE;
      end else if (!code[`RTF_TRIM_SIGN_BIT]) begin
         mode = RTF_TRIM_SLOW;
      end else begin
         mode = RTF_TRIM_FAST;
      end
      return mode;
   endfunction : trim_mode

   // Number of correction steps that a code asks for.
   function automatic logic [6:0] trim_steps(input rtf_code_type code);
      logic [7:0] wide;
      wide = 8'h00;
      if (!code[`RTF_TRIM_SIGN_BIT]) begin
         wide = {1'b0, code} - `RTF_TRIM_GAIN_BASE;
      end else begin
         wide = `RTF_TRIM_LOSS_BASE - {1'b0, code};
      end
      return wide[6:0];
   endfunction : trim_steps

   // Oscillator-domain state.
   logic osc_rst_n;
   logic osc_req_s;
   logic osc_ack_q;
   rtf_code_type osc_code_q;
   logic osc_tog_q;
   logic osc_sec_tog_q;
   logic osc_win_q;
   logic [15:0] presc_q;
   logic [4:0] sec_cnt_q;

   // System-domain state.
   logic halt_q;
   logic low_q;
   rtf_code_type trim_q;
   logic trim_act_q;
   logic [`RTF_CTRL_W-1:0] ctrl_q;
   logic [`RTF_IRQ_W-1:0] irq_q;
   logic sample_q;
   logic sec_tick_q;
   logic sec_seen_q;
   logic osc_seen_q;
   logic [31:0] wd_q;
   logic req_q;
   rtf_code_type xfer_q;

   // Synchronised inputs in the system domain.
   logic ce_s;
   logic below_2v1_s;
   logic below_1v6_s;
   logic osc_s;
   logic win_s;
   logic sec_s;
   logic ack_s;

   rtf_sync #(
      .WIDTH(7),
      .RESET_VAL(7'h00)
   ) u_sync_sys (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d({chip_enable, supply_below_2v1, supply_below_1v6, osc_tog_q,
          osc_win_q, osc_sec_tog_q, osc_ack_q}),
      .q({ce_s, below_2v1_s, below_1v6_s, osc_s, win_s, sec_s, ack_s})
   );

   rtf_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b0)
   ) u_sync_osc_rst (
      .clk(osc_clk),
      .rst_n(1'b1),
      .d(rst_n),
      .q(osc_rst_n)
   );

   rtf_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b0)
   ) u_sync_osc_req (
      .clk(osc_clk),
      .rst_n(osc_rst_n),
      .d(req_q),
      .q(osc_req_s)
   );

   // Oscillator-domain decoding of the second length.
   rtf_mode_type osc_mode;
   logic [15:0] osc_delta;
   logic osc_corr_sec;
   logic [15:0] osc_last;
   logic osc_sec_end;
   logic osc_new_code;

   assign osc_mode = trim_mode(osc_code_q);
   assign osc_delta = 16'({9'h000, trim_steps(osc_code_q)} * `RTF_TRIM_STEP);
   assign osc_corr_sec = (sec_cnt_q == `RTF_TRIM_LAST_SEC);
   assign osc_last = !osc_corr_sec ? `RTF_SEC_LAST :
      (osc_mode == RTF_TRIM_SLOW) ? `RTF_SEC_LAST + osc_delta :
      (osc_mode == RTF_TRIM_FAST) ? `RTF_SEC_LAST - osc_delta :
      `RTF_SEC_LAST;
   assign osc_sec_end = (presc_q >= osc_last);
   assign osc_new_code = (osc_req_s != osc_ack_q);

   // Trimmed prescaler and twenty-second frame on the oscillator clock.
   always_ff @(posedge osc_clk) begin
      if (!osc_rst_n) begin
         presc_q <= 16'h0000;
         sec_cnt_q <= 5'h00;
         osc_sec_tog_q <= 1'b0;
      end else if (osc_sec_end) begin
         presc_q <= 16'h0000;
         sec_cnt_q <= osc_corr_sec ? 5'h00 : sec_cnt_q + 5'h01;
         osc_sec_tog_q <= ~osc_sec_tog_q;
      end else begin
         presc_q <= presc_q + 16'h0001;
      end
   end

   // Activity toggle, sampling window and code capture.
   always_ff @(posedge osc_clk) begin
      if (!osc_rst_n) begin
         osc_tog_q <= 1'b0;
         osc_win_q <= 1'b0;
         osc_ack_q <= 1'b0;
         osc_code_q <= `RTF_TRIM_RST;
      end else begin
         osc_tog_q <= ~osc_tog_q;
         osc_win_q <= osc_sec_end || (presc_q < 16'(WIN_CYCLES - 1));
         osc_ack_q <= osc_req_s;
         if (osc_new_code) begin
            osc_code_q <= xfer_q;
         end
      end
   end

   // System-domain decoding.
   logic xfer_idle;
   logic xfer_start;
   logic osc_edge;
   logic wd_expired;
   logic halt_set;
   logic halt_rise;
   logic halt_clr;
   logic low_clr;
   logic below_sel;
   logic low_set;
   logic [`RTF_CTRL_W-1:0] ctrl_wdata;

   assign xfer_idle = (req_q == ack_s);
   assign xfer_start = xfer_idle && (xfer_q != trim_q);
   assign osc_edge = osc_s ^ osc_seen_q;
   assign wd_expired = (wd_q >= HALT_CYCLES - 1);
   assign halt_set = wd_expired && !ce_s;
   assign halt_rise = halt_set && !halt_q;
   assign halt_clr = flag_wr && !wr_osc_halt_flag;
   assign low_clr = flag_wr && !wr_low_supply_flag;
   assign below_sel = ctrl_q[`RTF_CTRL_VSEL] ? below_1v6_s : below_2v1_s;
   assign low_set = sample_q && below_sel;
   assign ctrl_wdata = {wr_scratch, wr_supply_threshold_select, wr_periodic_select,
      wr_test_mode, wr_clkout_enable_b, wr_clkout_enable_a, wr_hour24_select,
      wr_daily_alarm_enable, wr_weekly_alarm_enable};

   // Oscillator watchdog, seconds tick and code handover.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wd_q <= 32'h00000000;
         osc_seen_q <= 1'b0;
         sec_seen_q <= 1'b0;
         sec_tick_q <= 1'b0;
         req_q <= 1'b0;
         xfer_q <= `RTF_TRIM_RST;
      end else begin
         osc_seen_q <= osc_s;
         sec_seen_q <= sec_s;
         sec_tick_q <= sec_s ^ sec_seen_q;
         if (osc_edge) begin
            wd_q <= 32'h00000000;
         end else if (!wd_expired) begin
            wd_q <= wd_q + 32'h00000001;
         end
         if (xfer_start) begin
            xfer_q <= trim_q;
            req_q <= ~req_q;
         end
      end
   end

   // Sticky halt and low-supply flags.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         halt_q <= `RTF_HALT_RST;
         low_q <= `RTF_LOW_RST;
         sample_q <= 1'b0;
      end else begin
         halt_q <= halt_set || (halt_q && !halt_clr);
         if (halt_rise) begin
            low_q <= 1'b0;
         end else begin
            low_q <= low_set || (low_q && !low_clr);
         end
         sample_q <= win_s && !low_q && !low_set;
      end
   end

   // Trim code and control bits.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         trim_q <= `RTF_TRIM_RST;
         ctrl_q <= `RTF_CTRL_RST;
         trim_act_q <= 1'b0;
      end else if (halt_rise) begin
         trim_q <= `RTF_TRIM_RST;
         ctrl_q <= `RTF_CTRL_RST;
         trim_act_q <= 1'b0;
      end else begin
         if (trim_wr) begin
            trim_q <= trim_wdata;
         end
         if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata;
         end
         trim_act_q <= (trim_mode(trim_q) != RTF_TRIM_NONE);
      end
   end

   // Interrupt flags, set by events and cleared by zero writes.
   genvar gi;
   generate
      for (gi = 0; gi < `RTF_IRQ_W; gi = gi + 1) begin : g_irq
         logic irq_clr;
         assign irq_clr = flag_wr && !wr_irq_flag[gi];
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               irq_q[gi] <= 1'b0;
            end else if (halt_rise) begin
               irq_q[gi] <= 1'b0;
            end else begin
               irq_q[gi] <= irq_event[gi] || (irq_q[gi] && !irq_clr);
            end
         end
      end
   endgenerate

   assign osc_halt_flag = halt_q;
   assign low_supply_flag = low_q;
   assign trim_code = trim_q;
   assign trim_active = trim_act_q;
   assign weekly_alarm_enable = ctrl_q[`RTF_CTRL_WEEKLY_ALARM_ENABLE];
   assign daily_alarm_enable = ctrl_q[`RTF_CTRL_DAILY_ALARM_ENABLE];
   assign hour24_select = ctrl_q[`RTF_CTRL_H24];
   assign clkout_enable_a = ctrl_q[`RTF_CTRL_CLKA];
   assign clkout_enable_b = ctrl_q[`RTF_CTRL_CLKB];
   assign test_mode = ctrl_q[`RTF_CTRL_TEST];
   assign periodic_select = ctrl_q[`RTF_CTRL_PSEL+2:`RTF_CTRL_PSEL];
   assign supply_threshold_select = ctrl_q[`RTF_CTRL_VSEL];
   assign scratch = ctrl_q[`RTF_CTRL_SCR];
   assign irq_flag = irq_q;
   assign monitor_active = sample_q;
   assign sec_tick = sec_tick_q;

endmodule : rtf_trim_and_fault_flags

`default_nettype wire

/* File: bench/rtf_osc_model.sv */
/*
   Oscillator stand-in: a 48 ns timebase clock that the bench can stop.
   Assumes the bench drives run, low to model a halted crystal.
*/
`timescale 1ns/1ps
`default_nettype none
module rtf_osc_model
   import rtf_pkg::*;
#(
   parameter real HALF = 24.0
) (
   input wire logic run,
   output logic osc_clk
);
   initial osc_clk = 1'b0;
   always begin
      #HALF;
      osc_clk = run ? ~osc_clk : 1'b0;
   end
endmodule : rtf_osc_model
`default_nettype wire

/* File: bench/rtf_trim_monitor.sv */
/*
   Port assertions of the trim and fault-flag block.
   Assumes it is bound to every instance of that block.
*/
`timescale 1ns/1ps
`default_nettype none
module rtf_trim_monitor
   import rtf_pkg::*;
#(
   parameter int unsigned HALT_CYCLES = 50,
   parameter int unsigned WIN_CYCLES = 255
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic chip_enable,
   input wire logic trim_wr,
   input wire logic [6:0] trim_wdata,
   input wire logic ctrl_wr,
   input wire logic wr_supply_threshold_select,
   input wire logic flag_wr,
   input wire logic wr_osc_halt_flag,
   input wire logic wr_low_supply_flag,
   input wire logic osc_halt_flag,
   input wire logic low_supply_flag,
   input wire logic [6:0] trim_code,
   input wire logic trim_active,
   input wire logic supply_threshold_select,
   input wire logic [2:0] irq_flag,
   input wire logic monitor_active
);
   wire off_code = trim_code inside {7'h00, 7'h01, 7'h40, 7'h41};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   AST_TRIM_LOAD: assert property (trim_wr |=> trim_code == $past(trim_wdata) || osc_halt_flag)
      else $error("trim code not loaded");
   AST_TRIM_OFF: assert property (!$rose(osc_halt_flag) |-> trim_active == !$past(off_code))
      else $error("trim active wrong for code");
   AST_HALT_LOW: assert property ($rose(osc_halt_flag) |-> !low_supply_flag)
      else $error("low flag kept on halt");
   AST_HALT_CLEAR: assert property ($rose(osc_halt_flag) |->
      trim_code == 7'h00 && irq_flag == 3'h0 && !supply_threshold_select && !trim_active)
      else $error("halt did not clear bits");
   AST_HALT_STICKY: assert property (osc_halt_flag && !(flag_wr && !wr_osc_halt_flag)
      |=> osc_halt_flag)
      else $error("halt flag dropped");
   AST_LOW_STICKY: assert property (low_supply_flag && !(flag_wr && !wr_low_supply_flag)
      |=> low_supply_flag || osc_halt_flag)
      else $error("low flag dropped");
   AST_LOW_CAUSE: assert property ($rose(low_supply_flag) |-> $past(monitor_active))
      else $error("low flag set outside window");
   AST_LOW_STOPS: assert property (low_supply_flag |-> !monitor_active)
      else $error("sampling while low flag set");
   AST_CE_BLOCKS: assert property (chip_enable [*6] |=> !$rose(osc_halt_flag))
      else $error("halt detected with chip enable high");
   AST_THRESH_WR: assert property (ctrl_wr |=>
      supply_threshold_select == $past(wr_supply_threshold_select) || osc_halt_flag)
      else $error("threshold select not loaded");
endmodule : rtf_trim_monitor
bind rtf_trim_and_fault_flags rtf_trim_monitor #(
   .HALT_CYCLES(HALT_CYCLES),
   .WIN_CYCLES(WIN_CYCLES)
) u_mon (.sys_clk, .rst_n, .chip_enable, .trim_wr, .trim_wdata, .ctrl_wr,
   .wr_supply_threshold_select, .flag_wr, .wr_osc_halt_flag, .wr_low_supply_flag,
   .osc_halt_flag, .low_supply_flag, .trim_code, .trim_active, .supply_threshold_select,
   .irq_flag, .monitor_active);
`default_nettype wire

/* File: bench/testbench.sv */
/*
   Self-checking bench of the trim and fault-flag block.
   Assumes the oscillator model and the bound monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rtf_pkg::*;
;
   localparam int HALT = 50;
   localparam int SEC = 32768 * 48 / 100;
   localparam int WIN = 255 * 48 / 100;
   logic sys_clk = 1'b0;
   logic rst_n, osc_run, osc_clk, chip_enable, supply_below_2v1, supply_below_1v6;
   logic trim_wr, ctrl_wr, flag_wr, wr_weekly_alarm_enable, wr_daily_alarm_enable;
   logic wr_hour24_select, wr_clkout_enable_a, wr_clkout_enable_b, wr_test_mode, wr_scratch;
   logic wr_supply_threshold_select, wr_osc_halt_flag, wr_low_supply_flag, trim_active;
   logic osc_halt_flag, low_supply_flag, weekly_alarm_enable, daily_alarm_enable;
   logic hour24_select, clkout_enable_a, clkout_enable_b, test_mode, supply_threshold_select;
   logic scratch, monitor_active, sec_tick;
   logic [6:0] trim_wdata, trim_code;
   logic [2:0] wr_periodic_select, wr_irq_flag, irq_event, periodic_select, irq_flag;
   int err_count;
   int tests_run;
   wire [10:0] ctrl_out = {weekly_alarm_enable, daily_alarm_enable, hour24_select,
      clkout_enable_a, clkout_enable_b, test_mode, periodic_select, supply_threshold_select,
      scratch};
   rtf_osc_model u_osc (.run(osc_run), .osc_clk);
   rtf_trim_and_fault_flags #(.HALT_CYCLES(HALT), .WIN_CYCLES(255)) i_dut (.sys_clk, .rst_n,
      .osc_clk, .chip_enable, .supply_below_2v1, .supply_below_1v6, .trim_wr, .trim_wdata,
      .ctrl_wr, .wr_weekly_alarm_enable, .wr_daily_alarm_enable, .wr_hour24_select,
      .wr_clkout_enable_a, .wr_clkout_enable_b, .wr_test_mode, .wr_periodic_select,
      .wr_supply_threshold_select, .wr_scratch, .flag_wr, .wr_osc_halt_flag,
      .wr_low_supply_flag, .wr_irq_flag, .irq_event, .osc_halt_flag, .low_supply_flag,
      .trim_code, .trim_active, .weekly_alarm_enable, .daily_alarm_enable, .hour24_select,
      .clkout_enable_a, .clkout_enable_b, .test_mode, .periodic_select,
      .supply_threshold_select, .scratch, .irq_flag, .monitor_active, .sec_tick);
   always #50 sys_clk = ~sys_clk;
   task automatic stop_test;
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int c);
      repeat (c) @(negedge sys_clk);
   endtask : tick
   task automatic wait_mon(input logic v);
      for (int i = 0; i < 17000 && monitor_active !== v; i++) tick(1);
   endtask : wait_mon
   task automatic wr_trim(input logic [6:0] v);
      tick(1);
      trim_wr = 1'b1;
      trim_wdata = v;
      tick(1);
      trim_wr = 1'b0;
   endtask : wr_trim
   task automatic wr_ctrl(input logic [10:0] v);
      tick(1);
      ctrl_wr = 1'b1;
      {wr_weekly_alarm_enable, wr_daily_alarm_enable, wr_hour24_select, wr_clkout_enable_a,
         wr_clkout_enable_b, wr_test_mode, wr_periodic_select, wr_supply_threshold_select,
         wr_scratch} = v;
      tick(1);
      ctrl_wr = 1'b0;
   endtask : wr_ctrl
   task automatic wr_flags(input logic h, input logic l);
      tick(1);
      flag_wr = 1'b1;
      {wr_osc_halt_flag, wr_low_supply_flag, wr_irq_flag} = {h, l, 3'h7};
      tick(1);
      flag_wr = 1'b0;
   endtask : wr_flags
   task automatic t_power_up;
      check(osc_halt_flag, 1'b1);
      check({trim_code, ctrl_out, irq_flag, low_supply_flag}, '0);
      wr_flags(1'b0, 1'b1);
      check(osc_halt_flag, 1'b0);
   endtask : t_power_up
   task automatic t_codes;
      logic [6:0] codes [10] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h02, 7'h3F, 7'h42, 7'h7F,
         7'h09, 7'h57};
      for (int i = 0; i < 10; i++) begin
         wr_trim(codes[i]);
         check(trim_code, codes[i]);
         tick(1);
         check(trim_active, i > 3);
      end
      wr_trim(7'h00);
   endtask : t_codes
   task automatic t_second;
      int s;
      int w;
      w = 0;
      for (int i = 0; i < 17000 && sec_tick !== 1'b1; i++) tick(1);
      tick(1);
      for (s = 1; s < 17000 && sec_tick !== 1'b1; s++) begin
         w += monitor_active;
         tick(1);
      end
      check(s >= SEC - 1 && s <= SEC + 2, 1'b1);
      check(w >= WIN - 4 && w <= WIN + 4, 1'b1);
   endtask : t_second
   task automatic t_low;
      supply_below_2v1 = 1'b1;
      wait_mon(1'b1);
      tick(6);
      check({low_supply_flag, monitor_active}, 2'b10);
      wr_flags(1'b1, 1'b1);
      check(low_supply_flag, 1'b1);
      supply_below_2v1 = 1'b0;
      wr_flags(1'b1, 1'b0);
      check(low_supply_flag, 1'b0);
   endtask : t_low
   task automatic t_thr;
      wr_ctrl(11'h5A6);
      check(ctrl_out, 11'h5A6);
      supply_below_2v1 = 1'b1;
      wait_mon(1'b1);
      tick(60);
      check(low_supply_flag, 1'b0);
      supply_below_1v6 = 1'b1;
      tick(6);
      check(low_supply_flag, 1'b1);
   endtask : t_thr
   task automatic t_halt;
      irq_event = 3'h7;
      tick(1);
      irq_event = 3'h0;
      check(irq_flag, 3'h7);
      wr_trim(7'h57);
      chip_enable = 1'b1;
      osc_run = 1'b0;
      tick(HALT * 3);
      check(osc_halt_flag, 1'b0);
      chip_enable = 1'b0;
      for (int i = 0; i < 30 && osc_halt_flag !== 1'b1; i++) tick(1);
      check({trim_code, ctrl_out, irq_flag, low_supply_flag}, '0);
      chip_enable = 1'b1;
      tick(5);
      check(osc_halt_flag, 1'b1);
   endtask : t_halt
   initial begin
      {rst_n, chip_enable, supply_below_2v1, supply_below_1v6} = '0;
      {trim_wr, ctrl_wr, flag_wr, trim_wdata, irq_event} = '0;
      wr_ctrl_init: {wr_weekly_alarm_enable, wr_daily_alarm_enable, wr_hour24_select,
         wr_clkout_enable_a, wr_clkout_enable_b, wr_test_mode, wr_periodic_select,
         wr_supply_threshold_select, wr_scratch} = '0;
      {wr_osc_halt_flag, wr_low_supply_flag, wr_irq_flag} = '1;
      osc_run = 1'b1;
      err_count = 0;
      tests_run = 0;
      tick(4);
      rst_n = 1'b1;
      t_power_up();
      t_codes();
      t_second();
      t_low();
      t_thr();
      t_halt();
      stop_test();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
